// ### include/gpio_mux_pkg.sv
// Constants and types shared by the pin output source multiplexer
package gpio_mux_pkg;

   // ---------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // ---------------------------------------------------------------
   localparam int          ADDR_W          = 12;
   localparam logic [9:0]  PIN1_CTL_IDX    = 10'h011;
   localparam logic [9:0]  PIN2_CTL_IDX    = 10'h012;
   localparam logic [9:0]  PIN3_CTL_IDX    = 10'h013;
   localparam logic [9:0]  FS_CTL_IDX      = 10'h018;
   localparam logic [9:0]  PORT_EN_IDX     = 10'h01c;
   localparam logic [9:0]  STATUS_IDX      = 10'h01d;

   // ---------------------------------------------------------------
   // Reset values and field positions
   // ---------------------------------------------------------------
   localparam logic [7:0]  PIN_CTL_RESET   = 8'h00;
   localparam logic [7:0]  FS_CTL_RESET    = 8'h00;
   localparam logic [1:0]  PORT_EN_RESET   = 2'h3;
   localparam int          FS_GEN_ON_BIT   = 0;
   localparam int          NUM_PINS        = 3;
   localparam int          NUM_PORTS       = 2;

   // ---------------------------------------------------------------
   // Source and select encodings
   // ---------------------------------------------------------------
   localparam logic [2:0]  SRC_PORT0       = 3'h0;
   localparam logic [2:0]  SRC_PORT1       = 3'h1;
   localparam logic [2:0]  SRC_STATUS      = 3'h4;
   localparam logic [2:0]  SEL_REMOTE3     = 3'h3;
   localparam logic [2:0]  SEL_LOCK        = 3'h4;
   localparam logic [2:0]  SEL_PASS        = 3'h5;
   localparam logic [2:0]  SEL_LOCAL       = 3'h0;
   localparam logic [2:0]  SEL_OR_LOCK     = 3'h1;
   localparam logic [2:0]  SEL_AND_LOCK    = 3'h2;
   localparam logic [2:0]  SEL_AND_PASS    = 3'h3;
   localparam logic [2:0]  SEL_FRAME_SYNC  = 3'h4;

   // ---------------------------------------------------------------
   // Bus answers
   // ---------------------------------------------------------------
   localparam logic [1:0]  RESP_OKAY       = 2'h0;
   localparam logic [1:0]  RESP_SLVERR     = 2'h2;

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [2:0] value_select;
      logic [2:0] source_select;
      logic       local_value;
      logic       drive_enable;
   } pin_ctl_type;

   typedef struct packed {
      logic [3:0] remote_pins1;
      logic [3:0] remote_pins0;
      logic [1:0] lock;
      logic [1:0] pass;
   } link_status_type;

   typedef enum logic [1:0] {
      WR_IDLE = 2'b01,
      WR_RESP = 2'b10
   } wr_state_type;

   typedef enum logic [1:0] {
      RD_IDLE = 2'b01,
      RD_RESP = 2'b10
   } rd_state_type;

endpackage

// ### rtl/pin_source_mux.sv
// Per-pin output value selection
`timescale 1ns/1ns
module pin_source_mux
   import gpio_mux_pkg::*;
(
   input  wire pin_ctl_type     ctl,
   input  wire link_status_type link,
   input  wire logic            or_lock,
   input  wire logic            and_lock,
   input  wire logic            and_pass,
   input  wire logic            frame_sync,
   output logic                 value
);

   logic [3:0] remote;
   logic       port;

   always_comb begin
      port   = ctl.source_select[0];
      remote = port ? link.remote_pins1 : link.remote_pins0;
      // Reserved codes and a disabled pin give a defined low
      value  = 1'b0; // R11
      if (ctl.drive_enable) begin
         case (ctl.source_select) // R01
            SRC_PORT0, SRC_PORT1: begin
               if (ctl.value_select <= SEL_REMOTE3) begin
                  value = remote[ctl.value_select[1:0]]; // R02
               end else if (ctl.value_select == SEL_LOCK) begin
                  value = link.lock[port]; // R03
               end else if (ctl.value_select == SEL_PASS) begin
                  value = link.pass[port]; // R03
               end
            end
            SRC_STATUS: begin
               case (ctl.value_select) // R09
                  SEL_LOCAL:      value = ctl.local_value; // R04
                  SEL_OR_LOCK:    value = or_lock; // R05
                  SEL_AND_LOCK:   value = and_lock; // R05
                  SEL_AND_PASS:   value = and_pass; // R05
                  SEL_FRAME_SYNC: value = frame_sync; // R06
                  default:        value = 1'b0; // R11
               endcase
            end
            default: value = 1'b0; // R11
         endcase
      end
   end

endmodule

// ### rtl/gpio_output_source_mux.sv
// Output multiplexer, enables and register slave for pins 1 to 3
//
// Summary of operation
// (R01) Source field bits 4:2 picks port or status
// (R02) Port source, select 0-3 forwards remote pin
// (R03) Port source, select 4 lock, 5 pass
// (R04) Status source, select 0 gives local value
// (R05) Status selects 1-3: OR/AND lock, AND pass
// (R06) Status select 4 routes frame sync
// (R07) Pin driven only while bit 0 set
// (R08) Bit 1 holds writable local pin value
// (R09) Bits 7:5 hold select, meaning per source
// (R10) Frame sync generator runs only when enabled
// (R11) Reserved codes drive defined low level
// (R12) Pin control fields reset to zero, outputs off
//
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/1ns
module gpio_output_source_mux
   import gpio_mux_pkg::*;
#(
   parameter int FS_CNT_W       = 16,
   parameter int FS_HIGH_CYCLES = 100,
   parameter int FS_LOW_CYCLES  = 100
)(
   input  wire logic                clock,
   input  wire logic                rst_b,
   input  wire logic                awvalid,
   output logic                     awready,
   input  wire logic [ADDR_W-1:0]   awaddr,
   input  wire logic                wvalid,
   output logic                     wready,
   input  wire logic [31:0]         wdata,
   input  wire logic [3:0]          wstrb,
   output logic                     bvalid,
   input  wire logic                bready,
   output logic [1:0]               bresp,
   input  wire logic                arvalid,
   output logic                     arready,
   input  wire logic [ADDR_W-1:0]   araddr,
   output logic                     rvalid,
   input  wire logic                rready,
   output logic [31:0]              rdata,
   output logic [1:0]               rresp,
   input  wire link_status_type     link,
   output logic [NUM_PINS-1:0]      pin_out,
   output logic [NUM_PINS-1:0]      pin_oe
);

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   pin_ctl_type            ctl_q [NUM_PINS];
   pin_ctl_type            ctl_d [NUM_PINS];
   logic [7:0]             fs_ctl_q, fs_ctl_d;
   logic [1:0]             port_en_q, port_en_d;
   wr_state_type           wr_state_q, wr_state_d;
   rd_state_type           rd_state_q, rd_state_d;
   logic                   aw_held_q, aw_held_d;
   logic                   w_held_q, w_held_d;
   logic [ADDR_W-1:0]      aw_addr_q, aw_addr_d;
   logic [7:0]             w_byte_q, w_byte_d;
   logic                   w_lane_q, w_lane_d;
   logic [1:0]             bresp_q, bresp_d;
   logic [31:0]            rdata_q, rdata_d;
   logic [1:0]             rresp_q, rresp_d;
   logic [FS_CNT_W-1:0]    fs_cnt_q, fs_cnt_d;
   logic                   fs_level_q, fs_level_d;
   logic [NUM_PINS-1:0]    pin_out_q, pin_out_d;
   logic [NUM_PINS-1:0]    pin_oe_q, pin_oe_d;
   logic [NUM_PINS-1:0]    pin_value;
   logic                   or_lock, and_lock, and_pass;
   logic                   frame_sync_gen_on;
   logic                   do_write;
   logic [9:0]             wr_idx, rd_idx;

   localparam logic [FS_CNT_W-1:0] FS_HIGH_LAST =
      FS_CNT_W'(FS_HIGH_CYCLES - 1);
   localparam logic [FS_CNT_W-1:0] FS_LOW_LAST =
      FS_CNT_W'(FS_LOW_CYCLES - 1);

   assign frame_sync_gen_on = fs_ctl_q[FS_GEN_ON_BIT];

   // ---------------------------------------------------------------
   // Status combinations over enabled ports
   // ---------------------------------------------------------------
   // With no port enabled the AND terms read low, not vacuously high
   always_comb begin
      or_lock  = |(link.lock & port_en_q); // R05
      and_lock = (|port_en_q) & (&(link.lock | ~port_en_q)); // R05
      and_pass = (|port_en_q) & (&(link.pass | ~port_en_q)); // R05
   end

   // ---------------------------------------------------------------
   // Frame sync generator
   // ---------------------------------------------------------------
   always_comb begin
      fs_cnt_d   = fs_cnt_q;
      fs_level_d = fs_level_q;
      if (!frame_sync_gen_on) begin
         fs_cnt_d   = '0; // R10
         fs_level_d = 1'b0; // R10
      end else if (fs_cnt_q == (fs_level_q ? FS_HIGH_LAST : FS_LOW_LAST))
      begin
         fs_cnt_d   = '0;
         fs_level_d = ~fs_level_q;
      end else begin
         fs_cnt_d   = fs_cnt_q + 1'b1;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         fs_cnt_q   <= '0;
         fs_level_q <= 1'b0;
      end else begin
         fs_cnt_q   <= fs_cnt_d;
         fs_level_q <= fs_level_d;
      end
   end

   // ---------------------------------------------------------------
   // Pin multiplexers and registered outputs
   // ---------------------------------------------------------------
   for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
      pin_source_mux u_mux (
         .ctl        (ctl_q[i]),
         .link       (link),
         .or_lock    (or_lock),
         .and_lock   (and_lock),
         .and_pass   (and_pass),
         .frame_sync (fs_level_q),
         .value      (pin_value[i])
      );
   end

   always_comb begin
      pin_out_d = pin_value;
      for (int i = 0; i < NUM_PINS; i++) begin
         pin_oe_d[i] = ctl_q[i].drive_enable; // R07
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         pin_out_q <= '0;
         pin_oe_q  <= '0;
      end else begin
         pin_out_q <= pin_out_d;
         pin_oe_q  <= pin_oe_d;
      end
   end

   assign pin_out = pin_out_q;
   assign pin_oe  = pin_oe_q;

   // ---------------------------------------------------------------
   // Write channels
   // ---------------------------------------------------------------
   // Address and data are caught separately so either may come first
   assign awready = !aw_held_q && (wr_state_q == WR_IDLE);
   assign wready  = !w_held_q && (wr_state_q == WR_IDLE);
   assign bvalid  = (wr_state_q == WR_RESP);
   assign bresp   = bresp_q;

   always_comb begin
      aw_held_d  = aw_held_q;
      w_held_d   = w_held_q;
      aw_addr_d  = aw_addr_q;
      w_byte_d   = w_byte_q;
      w_lane_d   = w_lane_q;
      wr_state_d = wr_state_q;
      bresp_d    = bresp_q;
      fs_ctl_d   = fs_ctl_q;
      port_en_d  = port_en_q;
      for (int i = 0; i < NUM_PINS; i++) begin
         ctl_d[i] = ctl_q[i];
      end
      if (awvalid && awready) begin
         aw_held_d = 1'b1;
         aw_addr_d = awaddr;
      end
      if (wvalid && wready) begin
         w_held_d = 1'b1;
         w_byte_d = wdata[7:0];
         w_lane_d = wstrb[0];
      end
      do_write = aw_held_d && w_held_d && (wr_state_q == WR_IDLE);
      wr_idx   = aw_addr_d[ADDR_W-1:2];
      case (wr_state_q)
         WR_IDLE: begin
            if (do_write) begin
               aw_held_d  = 1'b0;
               w_held_d   = 1'b0;
               wr_state_d = WR_RESP;
               bresp_d    = RESP_OKAY;
               if (wr_idx == PIN1_CTL_IDX) begin
                  if (w_lane_d) ctl_d[0] = pin_ctl_type'(w_byte_d); // R08
               end else if (wr_idx == PIN2_CTL_IDX) begin
                  if (w_lane_d) ctl_d[1] = pin_ctl_type'(w_byte_d); // R08
               end else if (wr_idx == PIN3_CTL_IDX) begin
                  if (w_lane_d) ctl_d[2] = pin_ctl_type'(w_byte_d); // R08
               end else if (wr_idx == FS_CTL_IDX) begin
                  if (w_lane_d) fs_ctl_d = w_byte_d; // R10
               end else if (wr_idx == PORT_EN_IDX) begin
                  if (w_lane_d) port_en_d = w_byte_d[1:0];
               end else if (wr_idx == STATUS_IDX) begin
                  bresp_d = RESP_OKAY;
               end else begin
                  bresp_d = RESP_SLVERR;
               end
            end
         end
         WR_RESP: begin
            if (bready) begin
               wr_state_d = WR_IDLE;
            end
         end
         default: wr_state_d = WR_IDLE;
      endcase
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         aw_held_q  <= 1'b0;
         w_held_q   <= 1'b0;
         aw_addr_q  <= '0;
         w_byte_q   <= 8'h00;
         w_lane_q   <= 1'b0;
         wr_state_q <= WR_IDLE;
         bresp_q    <= RESP_OKAY;
         fs_ctl_q   <= FS_CTL_RESET;
         port_en_q  <= PORT_EN_RESET;
         for (int i = 0; i < NUM_PINS; i++) begin
            ctl_q[i] <= pin_ctl_type'(PIN_CTL_RESET); // R12
         end
      end else begin
         aw_held_q  <= aw_held_d;
         w_held_q   <= w_held_d;
         aw_addr_q  <= aw_addr_d;
         w_byte_q   <= w_byte_d;
         w_lane_q   <= w_lane_d;
         wr_state_q <= wr_state_d;
         bresp_q    <= bresp_d;
         fs_ctl_q   <= fs_ctl_d;
         port_en_q  <= port_en_d;
         for (int i = 0; i < NUM_PINS; i++) begin
            ctl_q[i] <= ctl_d[i];
         end
      end
   end

   // ---------------------------------------------------------------
   // Read channel
   // ---------------------------------------------------------------
   assign arready = (rd_state_q == RD_IDLE);
   assign rvalid  = (rd_state_q == RD_RESP);
   assign rdata   = rdata_q;
   assign rresp   = rresp_q;

   always_comb begin
      rd_state_d = rd_state_q;
      rdata_d    = rdata_q;
      rresp_d    = rresp_q;
      rd_idx     = araddr[ADDR_W-1:2];
      case (rd_state_q)
         RD_IDLE: begin
            if (arvalid) begin
               rd_state_d = RD_RESP;
               rresp_d    = RESP_OKAY;
               rdata_d    = 32'h0000_0000;
               if (rd_idx == PIN1_CTL_IDX) begin
                  rdata_d[7:0] = ctl_q[0];
               end else if (rd_idx == PIN2_CTL_IDX) begin
                  rdata_d[7:0] = ctl_q[1];
               end else if (rd_idx == PIN3_CTL_IDX) begin
                  rdata_d[7:0] = ctl_q[2];
               end else if (rd_idx == FS_CTL_IDX) begin
                  rdata_d[7:0] = fs_ctl_q;
               end else if (rd_idx == PORT_EN_IDX) begin
                  rdata_d[1:0] = port_en_q;
               end else if (rd_idx == STATUS_IDX) begin
                  rdata_d[7:0] = {pin_out_q, fs_level_q, link.pass,
                                  link.lock};
               end else begin
                  rresp_d = RESP_SLVERR;
               end
            end
         end
         RD_RESP: begin
            if (rready) begin
               rd_state_d = RD_IDLE;
            end
         end
         default: rd_state_d = RD_IDLE;
      endcase
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         rd_state_q <= RD_IDLE;
         rdata_q    <= 32'h0000_0000;
         rresp_q    <= RESP_OKAY;
      end else begin
         rd_state_q <= rd_state_d;
         rdata_q    <= rdata_d;
         rresp_q    <= rresp_d;
      end
   end

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_b);

   chk_oe_follows_en: assert property ( // R07
      pin_oe[1] == $past(ctl_q[1].drive_enable))
      else $error("pin 2 enable does not follow its control bit");

   chk_local_value: assert property ( // R04
      (ctl_q[0] == pin_ctl_type'({SEL_LOCAL, SRC_STATUS, 2'b11}))
      |=> pin_out[0])
      else $error("pin 1 does not show its local value");

   chk_remote_fwd: assert property ( // R02
      (ctl_q[0].drive_enable && ctl_q[0].source_select == SRC_PORT1
       && ctl_q[0].value_select <= SEL_REMOTE3)
      |=> pin_out[0] ==
          $past(link.remote_pins1[ctl_q[0].value_select[1:0]]))
      else $error("pin 1 does not forward the remote pin");

   chk_port_lock: assert property ( // R03
      (ctl_q[2].drive_enable && ctl_q[2].source_select == SRC_PORT0
       && ctl_q[2].value_select == SEL_LOCK)
      |=> pin_out[2] == $past(link.lock[0]))
      else $error("pin 3 does not show port 0 lock");

   chk_or_lock: assert property ( // R05
      (ctl_q[1].drive_enable && ctl_q[1].source_select == SRC_STATUS
       && ctl_q[1].value_select == SEL_OR_LOCK)
      |=> pin_out[1] == $past(|(link.lock & port_en_q)))
      else $error("pin 2 does not show the lock OR");

   chk_fs_route: assert property ( // R06
      (ctl_q[0].drive_enable && ctl_q[0].source_select == SRC_STATUS
       && ctl_q[0].value_select == SEL_FRAME_SYNC)
      |=> pin_out[0] == $past(fs_level_q))
      else $error("pin 1 does not carry frame sync");

   chk_reserved_low: assert property ( // R11
      (ctl_q[2].source_select[2:1] == 2'b01 ||
       ctl_q[2].source_select > SRC_STATUS || !ctl_q[2].drive_enable)
      |=> !pin_out[2])
      else $error("pin 3 not low on reserved or disabled code");

   chk_fs_off: assert property ( // R10
      !frame_sync_gen_on [*2] |-> !fs_level_q)
      else $error("frame sync runs while generation is off");

   chk_reset_zero: assert property ( // R12
      $rose(rst_b) |-> (ctl_q[0] == '0 && ctl_q[1] == '0 &&
                        ctl_q[2] == '0 && pin_oe == '0))
      else $error("pin controls not cleared by reset");

   chk_write_answer: assert property ( // R08
      (do_write && wr_idx == PIN1_CTL_IDX && w_lane_d)
      |=> bvalid && ctl_q[0] == pin_ctl_type'($past(w_byte_d)))
      else $error("write not stored or not answered");

   cov_fs_on_pin:  cover property (pin_out[0] && pin_oe[0] &&
                                   ctl_q[0].value_select == SEL_FRAME_SYNC);
   cov_and_pass:   cover property (ctl_q[1].value_select == SEL_AND_PASS
                                   && pin_out[1]);
   cov_bad_read:   cover property (rvalid && rresp == RESP_SLVERR);
   cov_w_first:    cover property (w_held_q && !aw_held_q);

endmodule

// ### verif/pin_load_model.sv
// Load model for the three output pins
`timescale 1ns/1ns
module pin_load_model
   import gpio_mux_pkg::*;
(
   input  wire logic                clock,
   input  wire logic [NUM_PINS-1:0] pin_out,
   input  wire logic [NUM_PINS-1:0] pin_oe,
   output logic      [NUM_PINS-1:0] pad
);
   logic [NUM_PINS-1:0] last_q = '0;
   // Released pins toggle, so a stale level can never pass for a drive
   always_comb begin
      for (int i = 0; i < NUM_PINS; i++) begin
         pad[i] = pin_oe[i] ? pin_out[i] : ~last_q[i];
      end
   end
   always_ff @(posedge clock) begin
      last_q <= pad;
   end
endmodule

// ### verif/gpio_output_source_mux_tb_top.sv
// Self-checking bench for the pin output source multiplexer
`timescale 1ns/1ns
module gpio_output_source_mux_tb_top
   import gpio_mux_pkg::*;
;
   logic                clock = 1'b0;
   logic                rst_b, awvalid, wvalid, bready, arvalid, rready;
   logic                awready, wready, bvalid, arready, rvalid;
   logic [ADDR_W-1:0]   awaddr, araddr;
   logic [31:0]         wdata, rdata;
   logic [3:0]          wstrb;
   logic [1:0]          bresp, rresp;
   link_status_type     link;
   logic [NUM_PINS-1:0] pin_out, pin_oe, pad;
   logic [1:0]          port_en = PORT_EN_RESET;
   int                  err_count = 0;
   int                  compares = 0;
   int                  cycles = 0;

   gpio_output_source_mux #(.FS_HIGH_CYCLES(3), .FS_LOW_CYCLES(2)) dut_u (
      .clock(clock), .rst_b(rst_b), .awvalid(awvalid), .awready(awready),
      .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
      .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
      .arvalid(arvalid), .arready(arready), .araddr(araddr),
      .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
      .link(link), .pin_out(pin_out), .pin_oe(pin_oe));
   pin_load_model load_u (.clock(clock), .pin_out(pin_out),
      .pin_oe(pin_oe), .pad(pad));

   always #4 clock = ~clock;

   // ---------------------------------------------------------------
   // Bus, compare and reference helpers
   // ---------------------------------------------------------------
   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      compares++;
      if (g !== e) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic wr(input logic [9:0] idx, input logic [7:0] d,
                     input logic [1:0] er);
      @(posedge clock);
      awvalid <= 1'b1;
      awaddr  <= {idx, 2'b00};
      wvalid  <= 1'b1;
      wdata   <= {24'h5a5a5a, d};
      bready  <= 1'b1;
      forever begin
         @(posedge clock);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) begin
            bready <= 1'b0;
            chk("bresp", er, bresp);
            break;
         end
      end
   endtask

   task automatic rd(input logic [9:0] idx, output logic [31:0] d,
                     output logic [1:0] r);
      @(posedge clock);
      arvalid <= 1'b1;
      araddr  <= {idx, 2'b00};
      rready  <= 1'b1;
      forever begin
         @(posedge clock);
         if (arready) arvalid <= 1'b0;
         if (rvalid) begin
            d = rdata;
            r = rresp;
            rready <= 1'b0;
            break;
         end
      end
   endtask

   function automatic logic exp_pin(logic [7:0] c);
      logic [3:0] rp;
      if (!c[0]) return 1'b0;
      rp = c[2] ? link.remote_pins1 : link.remote_pins0;
      if (c[4:3] == 2'b00) begin
         if (!c[7]) return rp[c[6:5]];
         if (c[7:5] == SEL_LOCK) return link.lock[c[2]];
         if (c[7:5] == SEL_PASS) return link.pass[c[2]];
         return 1'b0;
      end
      if (c[4:2] != SRC_STATUS) return 1'b0;
      case (c[7:5])
         SEL_LOCAL:    return c[1];
         SEL_OR_LOCK:  return |(link.lock & port_en);
         SEL_AND_LOCK: return (port_en != 0) && &(link.lock | ~port_en);
         SEL_AND_PASS: return (port_en != 0) && &(link.pass | ~port_en);
         default:      return 1'b0;
      endcase
   endfunction

   // Pins follow a control change one edge after the write is taken
   task automatic set_chk(input int p, input logic [7:0] c);
      if (c != 0) wr(PIN1_CTL_IDX + 10'(p), c, RESP_OKAY);
      repeat (2) @(posedge clock);
      chk("pin_out", exp_pin(c), pin_out[p]);
      chk("pin_oe", c[0], pin_oe[p]);
      if (c[0]) chk("pad", exp_pin(c), pad[p]);
   endtask

   task automatic count_high(output int hi);
      hi = 0;
      repeat (20) begin
         @(posedge clock);
         hi += int'(pin_out[0]);
      end
   endtask

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic test_reset();
      logic [31:0] d;
      logic [1:0]  r;
      for (int p = 0; p < NUM_PINS; p++) begin
         rd(PIN1_CTL_IDX + 10'(p), d, r);
         chk("ctl_reset", {24'h0, PIN_CTL_RESET}, d);
      end
      chk("oe_reset", 0, pin_oe);
      chk("out_reset", 0, pin_out);
      $display("test_reset done");
   endtask

   task automatic test_port_source();
      logic [31:0] d;
      logic [1:0]  r;
      logic [7:0]  c;
      link <= 12'h5a6;
      for (int p = 0; p < NUM_PINS; p++)
         for (int s = 0; s < 2; s++)
            for (int v = 0; v < 8; v++) begin
               c = {3'(v), 3'(s), 2'b01};
               set_chk(p, c);
               rd(PIN1_CTL_IDX + 10'(p), d, r);
               chk("ctl_readback", {24'h0, c}, d);
            end
      $display("test_port_source done");
   endtask

   task automatic test_status();
      logic [31:0] d;
      logic [1:0]  r;
      for (int e = 0; e < 4; e++) begin
         wr(PORT_EN_IDX, 8'(e), RESP_OKAY);
         port_en = 2'(e);
         for (int l = 0; l < 4; l++) begin
            link <= {8'h5a, 2'(l), 2'(3 - l)};
            for (int p = 0; p < NUM_PINS; p++)
               set_chk(p, {3'(p + 1), SRC_STATUS, 2'b01});
         end
      end
      for (int p = 0; p < NUM_PINS; p++)
         for (int v = 0; v < 2; v++)
            set_chk(p, {SEL_LOCAL, SRC_STATUS, 1'(v), 1'b1});
      wr(PORT_EN_IDX, 8'h03, RESP_OKAY);
      port_en = 2'h3;
      rd(PORT_EN_IDX, d, r);
      chk("port_en_rb", 32'h0000_0003, d);
      // Status: pins all high, frame sync low, pass 00, lock 11
      rd(STATUS_IDX, d, r);
      chk("status_rb", 32'h0000_00e3, d);
      chk("status_resp", RESP_OKAY, r);
      $display("test_status done");
   endtask

   task automatic test_reserved();
      logic [7:0] rsv [10] = '{8'h09, 8'h0d, 8'h15, 8'h19, 8'h1d,
                               8'hc1, 8'he1, 8'hb1, 8'hd1, 8'hf1};
      link <= 12'hfff;
      foreach (rsv[i]) set_chk(1, rsv[i]);
      $display("test_reserved done");
   endtask

   task automatic test_disable();
      logic [31:0] d;
      logic [1:0]  r;
      for (int p = 0; p < NUM_PINS; p++) begin
         set_chk(p, 8'h12);
         set_chk(p, 8'h13);
      end
      // A write with byte lane 0 off is answered but not stored
      wstrb <= 4'h0;
      wr(PIN1_CTL_IDX, 8'hff, RESP_OKAY);
      wstrb <= 4'hf;
      rd(PIN1_CTL_IDX, d, r);
      chk("lane_off_keep", 32'h0000_0013, d);
      wr(10'h03f, 8'hff, RESP_SLVERR);
      rd(10'h03f, d, r);
      chk("unmapped_data", 0, d);
      chk("unmapped_resp", RESP_SLVERR, r);
      $display("test_disable done");
   endtask

   task automatic test_frame_sync();
      int hi;
      set_chk(0, 8'h91);
      count_high(hi);
      chk("fs_idle_high", 0, hi);
      wr(FS_CTL_IDX, 8'h01, RESP_OKAY);
      repeat (4) @(posedge clock);
      // Period of five cycles, three high: any 20 cycles hold 12 highs
      count_high(hi);
      chk("fs_run_high", 12, hi);
      wr(FS_CTL_IDX, 8'h00, RESP_OKAY);
      repeat (3) @(posedge clock);
      count_high(hi);
      chk("fs_off_high", 0, hi);
      $display("test_frame_sync done");
   endtask

   // ---------------------------------------------------------------
   // Run control
   // ---------------------------------------------------------------
   task automatic results();
      $display("compares %0d err_count %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         err_count++;
         results();
      end
   end

   initial begin
      rst_b = 1'b0;
      awvalid = 1'b0;
      wvalid = 1'b0;
      bready = 1'b0;
      arvalid = 1'b0;
      rready = 1'b0;
      awaddr = '0;
      araddr = '0;
      wdata = '0;
      wstrb = 4'hf;
      link = '0;
      repeat (4) @(posedge clock);
      rst_b <= 1'b1;
      test_reset();
      test_port_source();
      test_status();
      test_reserved();
      test_disable();
      test_frame_sync();
      results();
   end
endmodule
